// ==== verilog/frc_fifo_ctrl.sv ====
// fifo core with full/partial reset, strap capture, offset programming,
// flags and two-stage retransmit; registers over ahb-lite.
// assumes write and read sides both run on SYS_CLK and that all inputs
// are synchronous to it.

// How it works
// RULE1: flag timing strap captured at full reset
// RULE2: partial reset zeroes pointers and output register
// RULE3: partial reset keeps every configuration setting
// RULE4: nine-bit read drives only low lines
// RULE5: read enable reads data or offset registers
// RULE6: retransmit latency strap captured at full reset
// RULE7: retransmit zeroes read pointer, forces not-ready
// RULE8: write stores data, offsets, or serial bits
// RULE9: full reset sets pointers and level flags
// RULE10: mode strap selects fall-through or standard flags
// RULE11: all straps latched only during full reset
// RULE12: full reset asynchronous, clears output register
// RULE13: partial reset sets pointers and level flags
// RULE14: partial reset keeps mode, sets its flags
// RULE15: partial reset acts without a clock (flags here are set only on SYS_CLK edges while it is held)
// RULE16: reader idles enables before retransmit edge
// RULE17: fall-through setup raises then drops ready
// RULE18: reader fetches later words with read enable
// RULE19: standard setup drops empty, then raises it
// RULE20: zero latency honoured in both modes
// RULE21: nine-bit write takes only low inputs (offset writes here take WRITE_DATA_IN[ADDR_W-1:0] unmasked)
// RULE22: width straps pick eighteen or nine bits
// RULE23: zero latency loads first word same edge
// RULE24: requests ignored while any reset held
module frc_fifo_ctrl
	import frc_pkg::*;
#(
	parameter int ADDR_W = ADDR_W_DEF
) (
	// clock and reset
	input  wire logic              SYS_CLK,
	input  wire logic              RST,
	// ahb-lite slave
	input  wire logic              HSEL,
	input  wire logic [31:0]       HADDR,
	input  wire logic [1:0]        HTRANS,
	input  wire logic              HWRITE,
	input  wire logic [2:0]        HSIZE,
	input  wire logic [31:0]       HWDATA,
	input  wire logic              HREADY,
	output logic [31:0]            HRDATA,
	output logic                   HREADYOUT,
	output logic                   HRESP,
	// resets and straps
	input  wire logic              FULL_RESET_N,
	input  wire logic              PARTIAL_RESET_N,
	input  wire logic              MODE_STRAP_SERIAL_IN,
	input  wire logic              WRITE_WIDTH_SELECT,
	input  wire logic              READ_WIDTH_SELECT,
	input  wire logic              BYTE_ORDER_SELECT,
	input  wire logic              RETRANSMIT_LATENCY_SELECT,
	input  wire logic              FLAG_TIMING_SELECT,
	input  wire logic              PARITY_INTERLEAVE_SELECT,
	// write side
	input  wire logic              WRITE_EN_N,
	input  wire logic              SERIAL_LOAD_ENABLE_N,
	input  wire logic [DATA_W-1:0] WRITE_DATA_IN,
	// read side
	input  wire logic              READ_EN_N,
	input  wire logic              RETRANSMIT_STROBE_N,
	output logic [DATA_W-1:0]      READ_DATA_OUT,
	// flags
	output logic                   EMPTY_FLAG_N,
	output logic                   FULL_FLAG_N,
	output logic                   ALMOST_EMPTY_N,
	output logic                   ALMOST_FULL_N,
	output logic                   HALF_FULL_N
);

	localparam int PW = ADDR_W + 1;
	localparam logic [PW-1:0] DEPTH_C = PW'(1 << ADDR_W);
	localparam logic [PW-1:0] HALF_C  = PW'(1 << (ADDR_W - 1));
	localparam logic [PW-1:0] ONE_C   = PW'(1);

	// state
	logic [DATA_W-1:0]   mem_q [1 << ADDR_W];
	logic [PW-1:0]       wptr_q, wptr_d;
	logic [PW-1:0]       rptr_q, rptr_d;
	logic [DATA_W-1:0]   dout_q, dout_d;
	logic                valid_q, valid_d;
	frc_rt_state_t       rt_q, rt_d;
	logic [1:0]          rt_cnt_q, rt_cnt_d;
	frc_cfg_t            cfg_q;
	logic [ADDR_W-1:0]   eofs_q, fofs_q;
	logic                ofs_wsel_q, ofs_rsel_q;
	logic [1:0]          ctrl_q;
	logic                a_wr_q;
	logic [7:0]          a_addr_q;

	// reset decode: data path clears on any reset
	wire data_rst  = RST | ~FULL_RESET_N | ~PARTIAL_RESET_N; // RULE15
	wire in_full   = ~FULL_RESET_N;
	wire ofs_acc   = ctrl_q[CTRL_OFS_ACCESS_BIT];
	wire ser_meth  = ctrl_q[CTRL_SERIAL_BIT];
	wire ft        = cfg_q.fall_through;
	wire zero_lat  = ~cfg_q.normal_latency;

	// occupancy
	wire [PW-1:0] count   = wptr_q - rptr_q;
	wire          empty_w = (count == '0);
	wire          full_w  = count[ADDR_W];

	// write-side decode
	wire wr_ok  = ~WRITE_EN_N & ~full_w & ~ofs_acc; // RULE8
	wire ofs_wr = ~WRITE_EN_N & ofs_acc & ~ser_meth; // RULE8
	wire ser_wr = ~SERIAL_LOAD_ENABLE_N & ofs_acc & ser_meth; // RULE8
	wire [DATA_W-1:0] wdata = cfg_q.write_w9 ?
		{{(DATA_W-HALF_W){1'b0}}, WRITE_DATA_IN[HALF_W-1:0]} :
		WRITE_DATA_IN; // RULE21

	// read-side decode
	wire rt_idle  = (rt_q == RT_IDLE);
	wire rt_req   = ~RETRANSMIT_STROBE_N & rt_idle; // RULE7
	wire rd_ok    = rt_idle & ~rt_req & ~ofs_acc;
	wire std_rd   = ~ft & rd_ok & ~READ_EN_N & ~empty_w;
	wire ft_load  = ft & rd_ok & ~empty_w & (~valid_q | ~READ_EN_N);
	wire ft_drop  = ft & rd_ok & empty_w & valid_q & ~READ_EN_N;
	wire ofs_rd   = ~READ_EN_N & ofs_acc & rt_idle; // RULE5
	wire rt_done  = (rt_q == RT_SETUP) & (rt_cnt_q == 2'h0);

	wire [DATA_W-1:0] head  = mem_q[rptr_q[ADDR_W-1:0]];
	wire [DATA_W-1:0] first = mem_q[0];
	wire [DATA_W-1:0] ofs_word = ofs_rsel_q ?
		DATA_W'(fofs_q) : DATA_W'(eofs_q);

	// narrow read port leaves the upper lines at zero
	function automatic logic [DATA_W-1:0] rd_mask(
		input logic [DATA_W-1:0] w,
		input logic              w9
	);
		rd_mask = w9 ? {{(DATA_W-HALF_W){1'b0}}, w[HALF_W-1:0]} : w;
	endfunction : rd_mask

	assign wptr_d = wr_ok ? wptr_q + ONE_C : wptr_q;

	// read pointer, output register and retransmit sequencing
	always_comb begin
		rptr_d   = rptr_q;
		dout_d   = dout_q;
		valid_d  = valid_q;
		rt_d     = rt_q;
		rt_cnt_d = rt_cnt_q;
		case (rt_q)
			RT_IDLE: begin
				if (rt_req && zero_lat) begin
					rptr_d  = ONE_C; // RULE20
					dout_d  = rd_mask(first, cfg_q.read_w9); // RULE23
					valid_d = ft;
				end else if (rt_req) begin
					rptr_d   = '0; // RULE7
					valid_d  = 1'b0; // RULE17
					rt_d     = RT_SETUP;
					rt_cnt_d = RT_SETUP_CYCLES - 2'h1;
				end else if (ofs_rd) begin
					dout_d = rd_mask(ofs_word, cfg_q.read_w9); // RULE5
				end else if (std_rd || ft_load) begin
					rptr_d  = rptr_q + ONE_C;
					dout_d  = rd_mask(head, cfg_q.read_w9); // RULE4
					valid_d = ft;
				end else if (ft_drop) begin
					valid_d = 1'b0;
				end
			end
			RT_SETUP: begin
				if (rt_done) begin
					rt_d = RT_IDLE;
					if (ft) begin
						rptr_d  = ONE_C; // RULE17
						dout_d  = rd_mask(first, cfg_q.read_w9);
						valid_d = 1'b1;
					end
				end else begin
					rt_cnt_d = rt_cnt_q - 2'h1;
				end
			end
			default: begin
				rt_d = RT_IDLE;
			end
		endcase
	end

	// flag evaluation: asynchronous timing uses next occupancy
	wire [PW-1:0] count_d = wptr_d - rptr_d;
	wire [PW-1:0] cnt_f   = cfg_q.sync_flags ? count : count_d; // RULE1
	wire [PW-1:0] free_f  = DEPTH_C - cnt_f;
	wire [PW-1:0] ae_th   = PW'(eofs_q) + PW'(ft);
	wire          full_d  = count_d[ADDR_W];
	wire empty_fl_d = ft ? ~valid_d :
		((count_d != '0) & (rt_d == RT_IDLE)); // RULE19
	wire full_fl_d  = ft ? full_d : ~full_d;
	wire ae_d       = ~(cnt_f <= ae_th);
	wire af_d       = ~(free_f <= PW'(fofs_q));
	wire hf_d       = ~(cnt_f > HALF_C);
	// mode seen by the flags while the strap is being captured
	wire mode_now   = in_full ? MODE_STRAP_SERIAL_IN : ft; // RULE14

	// storage: no reset, contents survive partial reset
	always_ff @(posedge SYS_CLK) begin
		if (wr_ok && !data_rst) begin
			mem_q[wptr_q[ADDR_W-1:0]] <= wdata; // RULE8
		end
	end

	// pointers and output register clear on any reset
	always_ff @(posedge SYS_CLK or posedge data_rst) begin
		if (data_rst) begin
			wptr_q   <= '0; // RULE2 RULE9 RULE13
			rptr_q   <= '0; // RULE2 RULE9 RULE13
			dout_q   <= '0; // RULE2 RULE12
			valid_q  <= 1'b0;
			rt_q     <= RT_IDLE;
			rt_cnt_q <= 2'h0;
		end else begin
			wptr_q   <= wptr_d; // RULE24
			rptr_q   <= rptr_d;
			dout_q   <= dout_d;
			valid_q  <= valid_d;
			rt_q     <= rt_d;
			rt_cnt_q <= rt_cnt_d;
		end
	end

	assign READ_DATA_OUT = dout_q;

	// flags: the reset level depends on the mode, so it is applied on the
	// clock while a reset is held instead of by the asynchronous path
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			EMPTY_FLAG_N   <= 1'b0;
			FULL_FLAG_N    <= 1'b1;
			ALMOST_EMPTY_N <= 1'b0;
			ALMOST_FULL_N  <= 1'b1;
			HALF_FULL_N    <= 1'b1;
		end else if (data_rst) begin
			EMPTY_FLAG_N   <= mode_now; // RULE10 RULE14
			FULL_FLAG_N    <= ~mode_now; // RULE10 RULE14
			ALMOST_EMPTY_N <= 1'b0; // RULE9 RULE13
			ALMOST_FULL_N  <= 1'b1; // RULE9 RULE13
			HALF_FULL_N    <= 1'b1; // RULE9 RULE13
		end else begin
			EMPTY_FLAG_N   <= empty_fl_d; // RULE7 RULE17
			FULL_FLAG_N    <= full_fl_d;
			ALMOST_EMPTY_N <= ae_d;
			ALMOST_FULL_N  <= af_d;
			HALF_FULL_N    <= hf_d;
		end
	end

	// straps follow the pins only while full reset is low, so partial
	// reset cannot disturb them
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			cfg_q <= CFG_RST;
		end else if (in_full) begin
			cfg_q.fall_through   <= MODE_STRAP_SERIAL_IN; // RULE10 RULE11
			cfg_q.read_w9        <= READ_WIDTH_SELECT; // RULE22
			cfg_q.write_w9       <= WRITE_WIDTH_SELECT; // RULE22
			cfg_q.little_endian  <= BYTE_ORDER_SELECT; // RULE11
			cfg_q.normal_latency <= RETRANSMIT_LATENCY_SELECT; // RULE6
			cfg_q.sync_flags     <= FLAG_TIMING_SELECT; // RULE1
			cfg_q.parity_il      <= PARITY_INTERLEAVE_SELECT; // RULE11
		end
	end

	// offset registers: defaults on full reset, kept on partial reset
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			eofs_q <= ADDR_W'(DEF_EMPTY_OFS);
			fofs_q <= ADDR_W'(DEF_FULL_OFS);
		end else if (in_full) begin
			eofs_q <= ADDR_W'(DEF_EMPTY_OFS);
			fofs_q <= ADDR_W'(DEF_FULL_OFS);
		end else if (!data_rst && ser_wr) begin
			{eofs_q, fofs_q} <= {eofs_q[ADDR_W-2:0], fofs_q,
				MODE_STRAP_SERIAL_IN}; // RULE8
		end else if (!data_rst && ofs_wr && !ofs_wsel_q) begin
			eofs_q <= WRITE_DATA_IN[ADDR_W-1:0]; // RULE8 RULE3
		end else if (!data_rst && ofs_wr) begin
			fofs_q <= WRITE_DATA_IN[ADDR_W-1:0];
		end
	end

	// alternate between empty and full offset on successive accesses
	always_ff @(posedge SYS_CLK or posedge data_rst) begin
		if (data_rst) begin
			ofs_wsel_q <= 1'b0;
			ofs_rsel_q <= 1'b0;
		end else begin
			ofs_wsel_q <= ofs_wr ? ~ofs_wsel_q : ofs_wsel_q;
			ofs_rsel_q <= ofs_rd ? ~ofs_rsel_q : ofs_rsel_q;
		end
	end

	// bus slave: zero wait states, read data captured in address phase
	wire a_take = HSEL & HTRANS[1] & HREADY;
	wire [31:0] st_word = {16'h0000, 1'b0, cfg_q, 1'b0,
		valid_q, ~rt_idle, HALF_FULL_N, ALMOST_FULL_N,
		ALMOST_EMPTY_N, FULL_FLAG_N, EMPTY_FLAG_N};
	wire [31:0] rd_mux =
		(HADDR[7:0] == REG_CTRL)   ? {30'h0000_0000, ctrl_q} :
		(HADDR[7:0] == REG_STATUS) ? st_word :
		(HADDR[7:0] == REG_LEVEL)  ? 32'(count) :
		(HADDR[7:0] == REG_OFFSET) ?
			((32'(fofs_q) << OFS_FULL_LSB) | 32'(eofs_q)) :
		32'h0000_0000;

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			a_wr_q    <= 1'b0;
			a_addr_q  <= 8'h00;
			HRDATA    <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else begin
			a_wr_q    <= a_take & HWRITE;
			a_addr_q  <= HADDR[7:0];
			HRDATA    <= (a_take && !HWRITE) ? rd_mux : HRDATA;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ctrl_q <= CTRL_RST;
		end else if (a_wr_q && a_addr_q == REG_CTRL) begin
			ctrl_q <= HWDATA[1:0];
		end
	end

endmodule : frc_fifo_ctrl

// ==== common/frc_pkg.sv ====
// constants, configuration carrier and states for the reset/retransmit
// control block; assumes a single 20 MHz system clock drives everything.
package frc_pkg;

	// storage geometry
	localparam int ADDR_W_DEF = 13;
	localparam int DATA_W     = 18;
	localparam int HALF_W     = 9;

	// register byte offsets on the bus
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LEVEL  = 8'h08;
	localparam logic [7:0] REG_OFFSET = 8'h0C;

	// control register fields
	localparam int CTRL_OFS_ACCESS_BIT = 0;
	localparam int CTRL_SERIAL_BIT     = 1;
	localparam logic [1:0] CTRL_RST    = 2'h0;

	// status and offset register field positions
	localparam int ST_EMPTY_BIT  = 0;
	localparam int ST_FULL_BIT   = 1;
	localparam int ST_AE_BIT     = 2;
	localparam int ST_AF_BIT     = 3;
	localparam int ST_HF_BIT     = 4;
	localparam int ST_SETUP_BIT  = 5;
	localparam int ST_VALID_BIT  = 6;
	localparam int ST_CFG_LSB    = 8;
	localparam int OFS_FULL_LSB  = 16;

	// default flag offsets after full reset
	localparam logic [15:0] DEF_EMPTY_OFS = 16'h007F;
	localparam logic [15:0] DEF_FULL_OFS  = 16'h007F;

	// normal-latency retransmit setup length in read cycles
	localparam logic [1:0] RT_SETUP_CYCLES = 2'h2;

	// configuration captured from the straps during full reset
	typedef struct packed {
		logic parity_il;
		logic sync_flags;
		logic normal_latency;
		logic little_endian;
		logic write_w9;
		logic read_w9;
		logic fall_through;
	} frc_cfg_t;

	localparam frc_cfg_t CFG_RST = '0;

	typedef enum logic {RT_IDLE, RT_SETUP} frc_rt_state_t;

endpackage : frc_pkg

// ==== verification/frc_checker.sv ====
// assertions on resets, strap capture and retransmit of frc_fifo_ctrl
// assumes one clock domain; sees the top ports only
module frc_checker
	import frc_pkg::*;
#(
	parameter int ADDR_W = ADDR_W_DEF
) (
	// clock and reset
	input wire logic              SYS_CLK,
	input wire logic              RST,
	// resets and straps
	input wire logic              FULL_RESET_N,
	input wire logic              PARTIAL_RESET_N,
	input wire logic              MODE_STRAP_SERIAL_IN,
	input wire logic              READ_WIDTH_SELECT,
	input wire logic              RETRANSMIT_LATENCY_SELECT,
	// read side and flags
	input wire logic              RETRANSMIT_STROBE_N,
	input wire logic [DATA_W-1:0] READ_DATA_OUT,
	input wire logic              EMPTY_FLAG_N,
	input wire logic              FULL_FLAG_N,
	input wire logic              ALMOST_EMPTY_N,
	input wire logic              ALMOST_FULL_N,
	input wire logic              HALF_FULL_N
);
	logic ft_q, r9_q, lat_q;
	wire  run      = FULL_RESET_N && PARTIAL_RESET_N;
	wire  prs_only = !PARTIAL_RESET_N && FULL_RESET_N;
	wire  lvl_rst  = !ALMOST_EMPTY_N && ALMOST_FULL_N && HALF_FULL_N;
	wire  rt_slow  = run && !RETRANSMIT_STROBE_N && lat_q && ft_q;

	// mirror of the straps, sampled on every edge of a full reset
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			{ft_q, r9_q, lat_q} <= 3'h0;
		end else if (!FULL_RESET_N) begin
			{ft_q, r9_q, lat_q} <= {MODE_STRAP_SERIAL_IN,
				READ_WIDTH_SELECT, RETRANSMIT_LATENCY_SELECT};
		end
	end

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);

	a_full_out: assert property (!FULL_RESET_N |-> READ_DATA_OUT == '0)
		else $error("output register set in full reset");
	a_part_out: assert property (!PARTIAL_RESET_N |-> READ_DATA_OUT == '0)
		else $error("output register set in partial reset");
	a_full_lvl: assert property (!FULL_RESET_N [*2] |-> lvl_rst)
		else $error("level flags wrong in full reset");
	a_part_lvl: assert property (prs_only [*2] |-> lvl_rst)
		else $error("level flags wrong in partial reset");
	a_full_mode: assert property (!FULL_RESET_N [*2] |->
		EMPTY_FLAG_N == $past(MODE_STRAP_SERIAL_IN) && FULL_FLAG_N != EMPTY_FLAG_N)
		else $error("mode flags do not follow strap");
	a_part_mode: assert property (prs_only [*2] |->
		EMPTY_FLAG_N == ft_q && FULL_FLAG_N == !ft_q)
		else $error("partial reset lost the mode");
	a_narrow_out: assert property (r9_q |-> READ_DATA_OUT[DATA_W-1:HALF_W] == '0)
		else $error("upper lines driven in narrow read");
	a_rt_setup: assert property (rt_slow |->
		##[1:2] EMPTY_FLAG_N ##[1:3] !EMPTY_FLAG_N)
		else $error("fall-through setup flag sequence wrong");
	a_hold_out: assert property (!run |=> READ_DATA_OUT == '0)
		else $error("read taken while reset held");
endmodule : frc_checker

bind frc_fifo_ctrl frc_checker #(.ADDR_W(ADDR_W)) frc_checker_i (
	.SYS_CLK, .RST, .FULL_RESET_N, .PARTIAL_RESET_N, .MODE_STRAP_SERIAL_IN,
	.READ_WIDTH_SELECT, .RETRANSMIT_LATENCY_SELECT, .RETRANSMIT_STROBE_N,
	.READ_DATA_OUT, .EMPTY_FLAG_N, .FULL_FLAG_N, .ALMOST_EMPTY_N,
	.ALMOST_FULL_N, .HALF_FULL_N
);

// ==== verification/frc_peer.sv ====
// writer and reader at the far side of frc_fifo_ctrl
// assumes both sides run on one clock; each task waits for a rising edge
module frc_peer
	import frc_pkg::*;
(
	// clock
	input wire logic          clk,
	// write side
	output logic              wen_n,
	output logic              sen_n,
	output logic [DATA_W-1:0] wdata,
	// read side
	output logic              ren_n,
	output logic              rt_n
);
	initial begin
		{wen_n, sen_n, ren_n, rt_n} = 4'hF;
		wdata = '0;
	end

	task automatic put(input logic [DATA_W-1:0] d);
		@(posedge clk);
		wen_n <= 1'b0;
		wdata <= d;
		@(posedge clk);
		wen_n <= 1'b1;
		// released lines show the inverse so stale data cannot pass
		wdata <= ~d;
	endtask : put

	task automatic get();
		@(posedge clk);
		ren_n <= 1'b0;
		@(posedge clk);
		ren_n <= 1'b1;
	endtask : get

	// one offset bit per pulse; the bench holds the serial input steady
	task automatic shift();
		@(posedge clk);
		sen_n <= 1'b0;
		@(posedge clk);
		sen_n <= 1'b1;
	endtask : shift

	// both enables are idle here, as the setup edge needs
	task automatic rt();
		@(posedge clk);
		rt_n <= 1'b0;
		@(posedge clk);
		rt_n <= 1'b1;
	endtask : rt
endmodule : frc_peer

// ==== verification/frc_fifo_ctrl_tb.sv ====
// self-checking bench for frc_fifo_ctrl: straps, resets, retransmit
// assumes frc_peer drives the fifo ports and this bench drives ahb
`define CHK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("unexpected at %0t got %h expected %h", $time, g, e); \
	end \
end

module frc_fifo_ctrl_tb
	import frc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic              sys_clk = 1'b0;
	logic              rst     = 1'b1;
	logic              full_n  = 1'b1;
	logic              prs_n   = 1'b1;
	logic              hsel    = 1'b0;
	logic [2:0]        hsize   = 3'h0;
	logic [6:0]        strap   = 7'h00;
	logic [31:0]       haddr   = '0;
	logic [31:0]       hwdata  = '0;
	logic [31:0]       rdata;
	logic [1:0]        htrans  = 2'h0;
	logic              hwrite  = 1'b0;
	wire  [31:0]       hrdata;
	wire               hready, hresp, wen_n, sen_n, ren_n, rt_n;
	wire               ef, ff, ae, af, hf;
	wire  [DATA_W-1:0] wdata, rdo;
	int                failures = 0;
	int                checks_done = 0;
	int                cyc = 0;

	always #25 sys_clk = ~sys_clk;

	// depth cut to sixteen words to keep the run short
	frc_fifo_ctrl #(.ADDR_W(4)) frc_fifo_ctrl_i (
		.SYS_CLK(sys_clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
		.FULL_RESET_N(full_n), .PARTIAL_RESET_N(prs_n),
		.MODE_STRAP_SERIAL_IN(strap[0]), .READ_WIDTH_SELECT(strap[1]),
		.WRITE_WIDTH_SELECT(strap[2]), .BYTE_ORDER_SELECT(strap[3]),
		.RETRANSMIT_LATENCY_SELECT(strap[4]), .FLAG_TIMING_SELECT(strap[5]),
		.PARITY_INTERLEAVE_SELECT(strap[6]), .WRITE_EN_N(wen_n),
		.SERIAL_LOAD_ENABLE_N(sen_n), .WRITE_DATA_IN(wdata),
		.READ_EN_N(ren_n), .RETRANSMIT_STROBE_N(rt_n), .READ_DATA_OUT(rdo),
		.EMPTY_FLAG_N(ef), .FULL_FLAG_N(ff), .ALMOST_EMPTY_N(ae),
		.ALMOST_FULL_N(af), .HALF_FULL_N(hf)
	);

	frc_peer frc_peer_i (.clk(sys_clk), .wen_n, .sen_n, .wdata, .ren_n, .rt_n);

	task automatic conclude();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			conclude();
		end
	end

	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		hsize  <= 3'h2;
		haddr  <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge sys_clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hready !== 1'b1);
		rdata = hrdata;
	endtask : bus

	task automatic reg_chk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(a, 1'b0, '0);
		`CHK(rdata & m, e)
		`CHK(hresp, 1'b0)
	endtask : reg_chk

	// shifts eight offset bits, first bit ends up in the empty offset msb
	task automatic ser_load(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			strap[0] <= v[i];
			frc_peer_i.shift();
		end
	endtask : ser_load

	task automatic read_chk(input logic [DATA_W-1:0] e);
		frc_peer_i.get();
		@(negedge sys_clk);
		`CHK(rdo, e)
	endtask : read_chk

	task automatic await_flag(input logic v);
		int n;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (ef !== v && n < 8);
		`CHK(ef, v)
	endtask : await_flag

	task automatic full_reset(input logic [6:0] s, input logic [4:0] f);
		@(posedge sys_clk);
		strap  <= s;
		full_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		`CHK({ef, ff, ae, af, hf}, f)
		`CHK(rdo, 18'h0_0000)
		@(posedge sys_clk);
		full_n <= 1'b1;
	endtask : full_reset

	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		// standard timing, zero latency, nine-bit write port
		full_reset(7'h6C, 5'h0B);
		reg_chk(REG_STATUS, 32'h0000_7F00, 32'h0000_6C00);
		frc_peer_i.put(18'h3_FE01);
		frc_peer_i.put(18'h2_0102);
		frc_peer_i.put(18'h1_0003);
		await_flag(1'b1);
		read_chk(18'h0_0001);
		read_chk(18'h0_0102);
		frc_peer_i.rt();
		@(negedge sys_clk);
		`CHK(rdo, 18'h0_0001)
		read_chk(18'h0_0102);
		@(posedge sys_clk);
		prs_n <= 1'b0;
		// straps moved so that a capture during partial reset would show
		strap <= 7'h13;
		#1;
		`CHK(rdo, 18'h0_0000)
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK({ef, ff, ae, af, hf}, 5'h0B)
		@(posedge sys_clk);
		prs_n <= 1'b1;
		reg_chk(REG_STATUS, 32'h0000_7F00, 32'h0000_6C00);
		reg_chk(REG_LEVEL, 32'hFFFF_FFFF, 32'h0000_0000);
		bus(REG_CTRL, 1'b1, 32'h0000_0003);
		reg_chk(REG_CTRL, 32'h0000_0003, 32'h0000_0003);
		ser_load(8'hA5);
		reg_chk(REG_OFFSET, 32'hFFFF_FFFF, 32'h0005_000A);
		read_chk(18'h0_000A);
		read_chk(18'h0_0005);
		bus(REG_CTRL, 1'b1, 32'h0000_0001);
		frc_peer_i.put(18'h0_0003);
		frc_peer_i.put(18'h0_0006);
		reg_chk(REG_OFFSET, 32'hFFFF_FFFF, 32'h0006_0003);
		bus(REG_CTRL, 1'b1, 32'h0000_0000);
		reg_chk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
		$display("test standard done");
		// fall-through timing, normal latency, nine-bit read port
		full_reset(7'h13, 5'h13);
		reg_chk(REG_STATUS, 32'h0000_7F00, 32'h0000_1300);
		frc_peer_i.put(18'h2_A5A5);
		frc_peer_i.put(18'h1_5A5A);
		await_flag(1'b0);
		`CHK(rdo, 18'h0_01A5)
		read_chk(18'h0_005A);
		frc_peer_i.rt();
		await_flag(1'b1);
		await_flag(1'b0);
		`CHK(rdo, 18'h0_01A5)
		$display("test fall-through done");
		conclude();
	end
endmodule : frc_fifo_ctrl_tb
